// ### rtl/scu_serial_unit.sv
`timescale 1ns/100ps
`include "scu_regs.svh"
module scu_serial_unit #(
  parameter int DIV_W = 16,
  parameter int DMA_W = 8
) (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  reset_n,
  // Register bus
  input  wire scu_pkg::scu_axil_req_s axi_req,
  output wire scu_pkg::scu_axil_rsp_s axi_rsp,
  // Serial pins
  input  wire scu_pkg::scu_pin_in_s  pin_in,
  output wire scu_pkg::scu_pin_out_s pin_out,
  // DMA channels
  input  wire scu_pkg::scu_dma_in_s  dma_in,
  output wire scu_pkg::scu_dma_out_s dma_out,
  // Interrupt request and vector
  output wire logic                  irq_request,
  output wire logic [7:0]            irq_vector
);
  logic [7:0]       cfmt_r, b9ctl_r, imask_r, match_r, ccfg_r, vecbase_r, irq_vec_r;
  logic [DIV_W-1:0] baud_r, baud_cnt_r;
  logic             baud_lvl_r, tx_clock_pin_q_r, rx_clock_pin_q_r, irq_req_r;
  logic             aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
  logic [7:0]       aw_addr_r;
  logic [31:0]      w_data_r, rdata_r, rd_word;
  logic [3:0]       w_strb_r;
  logic [1:0]       bresp_r, rresp_r;
  logic [8:0]       stat_r, st_set, rx_data_r;
  logic             rx_full_r, after_brk_r, rx_dma_req_r, tx_go_r;
  logic [1:0]       dma_on_r;
  logic [DMA_W-1:0] rx_dcnt_r, tx_dcnt_r;
  scu_pkg::scu_tx_state_e tx_st_r;
  scu_pkg::scu_rx_state_e rx_st_r;
  logic [3:0]       tx_cnt_r, rx_cnt_r, brk_cnt_r;
  logic [2:0]       tx_idx_r, rx_idx_r;
  logic [8:0]       thr_r, tsr_r;
  logic             thr_full_r, stop2nd_r;
  logic [7:0]       rsh_r;
  logic             r9_r, rpar_bad_r, rzero_r;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return {a[7:2], 2'b00} == off;
  endfunction : hit

  function automatic logic mapped(input logic [7:0] a);
    return {a[7:2], 2'b00} <= `SCU_OFF_UNIT_ST;
  endfunction : mapped

  // Register bus decode.
  wire do_wr  = aw_hold_r & w_hold_r & ~bvalid_r;
  wire do_rd  = axi_req.arvalid & ~rvalid_r;
  wire wr_b0  = do_wr & w_strb_r[0];
  wire wr_thr = wr_b0 & hit(aw_addr_r, `SCU_OFF_DATA);
  wire wr_bd  = wr_b0 & (hit(aw_addr_r, `SCU_OFF_BAUD_LO) | hit(aw_addr_r, `SCU_OFF_BAUD_HI));
  wire wr_dma = wr_b0 & hit(aw_addr_r, `SCU_OFF_DMA_CTL);
  wire rd_rxd = do_rd & hit(axi_req.araddr, `SCU_OFF_DATA);
  // A divider write restarts engines, flags and DMA but keeps settings.
  wire eng_rst = ~reset_n | wr_bd;

  // Format decode.
  wire       cd      = ccfg_r[`SCU_CC_CD];
  wire       mode2   = ccfg_r[`SCU_CC_MODE2];
  wire       ninth   = cfmt_r[`SCU_CF_NINTH];
  wire       par_en  = cfmt_r[`SCU_CF_PAR_EN];
  wire       stop2   = cfmt_r[`SCU_CF_STOP2];
  wire [2:0] len_m1  = {1'b0, cfmt_r[1:0]} + 3'h4;
  wire [7:0] dmask   = 8'hFF >> (~cfmt_r[1:0]);
  wire [3:0] frame_n = {1'b0, len_m1} + 4'h3 + {3'h0, ninth} + {3'h0, par_en} + {3'h0, stop2};
  wire       echo    = b9ctl_r[`SCU_BC_ECHO];
  wire       loop    = b9ctl_r[`SCU_BC_LOOP];
  wire       brk_req = b9ctl_r[`SCU_BC_BREAK];

  // Clock sources.
  wire baud_tick  = baud_cnt_r == (baud_r - DIV_W'(1));
  wire tx_ext_edg = pin_in.tx_clk & ~tx_clock_pin_q_r;
  wire rx_ext_edg = pin_in.rx_clk & ~rx_clock_pin_q_r;
  wire tx_pin_in  = ~ccfg_r[`SCU_CC_TX_CLOCK_PIN] & ~ccfg_r[`SCU_CC_TX_PIN_OUTPUT_SEL];
  wire tx_src     = tx_pin_in ? tx_ext_edg : baud_tick;
  wire rx_src     = (ccfg_r[`SCU_CC_XRX] | mode2) ? rx_ext_edg : baud_tick;
  wire tx_bit     = tx_src & (cd | (tx_cnt_r == `SCU_ASYNC_LAST));
  wire rx_smp     = rx_src & (cd | (rx_cnt_r == `SCU_ASYNC_LAST));

  // Transmit serial value and pin routing.
  wire tx_par = ^(tsr_r[7:0] & dmask) ^ cfmt_r[`SCU_CF_PAR_ODD];
  wire tx_ser = (tx_st_r == scu_pkg::TX_START) ? 1'b0 :
                (tx_st_r == scu_pkg::TX_DATA)  ? tsr_r[tx_idx_r] :
                (tx_st_r == scu_pkg::TX_NINTH) ? tsr_r[8] :
                (tx_st_r == scu_pkg::TX_PAR)   ? tx_par :
                (tx_st_r == scu_pkg::TX_BREAK) ? 1'b0 : 1'b1;
  wire rx_in  = loop ? tx_ser : pin_in.rx_line;
  // The clock out idles high in expansion mode outside the data bits only when SCU_CC_TX_CLOCK_PIN is set.
  wire sync_clk = (mode2 & (tx_st_r != scu_pkg::TX_DATA)) ? 1'b1 : baud_lvl_r;
  assign pin_out.tx_line    = echo ? pin_in.rx_line : (loop ? 1'b1 : tx_ser);
  assign pin_out.tx_clk_oe  = ~tx_pin_in;
  assign pin_out.tx_clk_out = ccfg_r[`SCU_CC_TX_CLOCK_PIN] ? sync_clk : baud_lvl_r;

  // Transmit events.
  wire stop_last  = ~stop2 | stop2nd_r;
  wire tx_may_go  = (tx_st_r == scu_pkg::TX_IDLE) | ((tx_st_r == scu_pkg::TX_STOP) & stop_last);
  wire ev_take    = tx_bit & tx_may_go & thr_full_r;
  wire ev_tsr_mt  = tx_bit & (tx_st_r == scu_pkg::TX_STOP) & stop_last & ~thr_full_r;
  wire dma_tx_req = dma_on_r[1] & tx_go_r & ~thr_full_r & ~rx_dma_req_r & (tx_dcnt_r != '0);
  wire dma_tx_ack = dma_tx_req & dma_in.tx_ack;
  wire dma_rx_ack = rx_dma_req_r & dma_in.rx_ack;
  wire thr_load   = (wr_thr & ~thr_full_r) | dma_tx_ack;
  wire [7:0] thr_byte = dma_tx_ack ? dma_in.tx_data : w_data_r[7:0];

  // Receive events.
  wire rx_par_exp = ^(rsh_r & dmask) ^ cfmt_r[`SCU_CF_PAR_ODD];
  wire rx_end  = rx_smp & (rx_st_r == scu_pkg::RX_STOP);
  wire ev_brk  = rx_end & ~rx_in & rzero_r;
  wire ev_frm  = rx_end & ~rx_in & ~rzero_r;
  wire ev_word = rx_end & ~ev_brk;
  wire ev_par  = ev_word & par_en & rpar_bad_r;
  wire ev_ovr  = ev_word & rx_full_r;
  wire mtch    = rsh_r == (match_r & dmask);
  wire [1:0] amode = {b9ctl_r[`SCU_BC_ADDR_IRQ_MODE_ON], cfmt_r[`SCU_CF_AMODE]};
  wire ev_addr = ev_word & ((amode == 2'h0) ? r9_r :
                            (amode == 2'h1) ? mtch :
                            (amode == 2'h2) ? (mtch & r9_r) : (mtch & after_brk_r));
  wire ev_rx_eob = dma_rx_ack & (rx_dcnt_r == DMA_W'(1));
  wire ev_tx_eob = dma_tx_ack & (tx_dcnt_r == DMA_W'(1));

  // Register bus slave.
  assign axi_rsp.awready = ~aw_hold_r & ~bvalid_r;
  assign axi_rsp.wready  = ~w_hold_r & ~bvalid_r;
  assign axi_rsp.bvalid  = bvalid_r;
  assign axi_rsp.bresp   = bresp_r;
  assign axi_rsp.arready = ~rvalid_r;
  assign axi_rsp.rvalid  = rvalid_r;
  assign axi_rsp.rdata   = rdata_r;
  assign axi_rsp.rresp   = rresp_r;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      rvalid_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bresp_r   <= `SCU_RESP_OKAY;
      rresp_r   <= `SCU_RESP_OKAY;
      rdata_r   <= 32'h0000_0000;
    end else begin
      if (axi_req.awvalid && axi_rsp.awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= axi_req.awaddr;
      end
      if (axi_req.wvalid && axi_rsp.wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= axi_req.wdata;
        w_strb_r <= axi_req.wstrb;
      end
      if (do_wr) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= mapped(aw_addr_r) ? `SCU_RESP_OKAY : `SCU_RESP_SLVERR;
      end else if (axi_req.bready) begin
        bvalid_r <= 1'b0;
      end
      if (do_rd) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_word;
        rresp_r  <= mapped(axi_req.araddr) ? `SCU_RESP_OKAY : `SCU_RESP_SLVERR;
      end else if (axi_req.rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    case ({axi_req.araddr[7:2], 2'b00})
      `SCU_OFF_DATA:     rd_word[8:0] = rx_data_r;
      `SCU_OFF_CHAR_FMT: rd_word[7:0] = cfmt_r;
      `SCU_OFF_BIT9_CTL: rd_word[7:0] = b9ctl_r;
      `SCU_OFF_IRQ_MASK: rd_word[7:0] = imask_r;
      `SCU_OFF_IRQ_STAT: rd_word[8:0] = stat_r;
      `SCU_OFF_MATCH:    rd_word[7:0] = match_r;
      `SCU_OFF_CLK_CFG:  rd_word[7:0] = ccfg_r;
      `SCU_OFF_BAUD_LO:  rd_word[7:0] = baud_r[7:0];
      `SCU_OFF_BAUD_HI:  rd_word[7:0] = baud_r[15:8];
      `SCU_OFF_IRQ_VEC:  rd_word[7:0] = irq_vec_r;
      `SCU_OFF_DMA_CTL:  rd_word[1:0] = dma_on_r;
      `SCU_OFF_TX_CNT:   rd_word[DMA_W-1:0] = tx_dcnt_r;
      `SCU_OFF_RX_CNT:   rd_word[DMA_W-1:0] = rx_dcnt_r;
      `SCU_OFF_UNIT_ST:  rd_word[3:0] = {rx_dma_req_r, tx_st_r != scu_pkg::TX_IDLE, rx_full_r, thr_full_r};
      default:           rd_word = 32'h0000_0000;
    endcase
  end

  // Settings survive the divider-write reset.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cfmt_r    <= 8'h00;
      b9ctl_r   <= 8'h00;
      imask_r   <= 8'h00;
      match_r   <= 8'h00;
      ccfg_r    <= 8'h00;
      vecbase_r <= 8'h00;
      baud_r    <= DIV_W'(`SCU_BAUD_RST);
    end else begin
      if (thr_load) begin
        b9ctl_r[`SCU_BC_SADDR] <= 1'b0;
      end
      if (wr_b0) begin
        if (hit(aw_addr_r, `SCU_OFF_CHAR_FMT)) cfmt_r <= w_data_r[7:0];
        if (hit(aw_addr_r, `SCU_OFF_BIT9_CTL)) b9ctl_r <= w_data_r[7:0];
        if (hit(aw_addr_r, `SCU_OFF_IRQ_MASK)) imask_r <= w_data_r[7:0];
        if (hit(aw_addr_r, `SCU_OFF_MATCH)) match_r <= w_data_r[7:0];
        if (hit(aw_addr_r, `SCU_OFF_CLK_CFG)) ccfg_r <= w_data_r[7:0];
        if (hit(aw_addr_r, `SCU_OFF_IRQ_VEC)) vecbase_r <= {w_data_r[7:3], 3'h0};
        if (hit(aw_addr_r, `SCU_OFF_BAUD_LO)) baud_r[7:0] <= w_data_r[7:0];
        if (hit(aw_addr_r, `SCU_OFF_BAUD_HI)) baud_r[15:8] <= w_data_r[7:0];
      end
    end
  end

  // Baud generator and pin edge detection.
  always_ff @(posedge clk_sys) begin
    if (eng_rst) begin
      baud_cnt_r <= '0;
      baud_lvl_r <= 1'b0;
      // Loading the pin level here keeps an idle-high clock pin from faking an edge after reset.
      tx_clock_pin_q_r  <= pin_in.tx_clk;
      rx_clock_pin_q_r  <= pin_in.rx_clk;
      tx_cnt_r   <= 4'h0;
    end else begin
      baud_cnt_r <= baud_tick ? '0 : baud_cnt_r + DIV_W'(1);
      baud_lvl_r <= baud_cnt_r >= (baud_r >> 1);
      tx_clock_pin_q_r  <= pin_in.tx_clk;
      rx_clock_pin_q_r  <= pin_in.rx_clk;
      if (tx_src) tx_cnt_r <= tx_cnt_r + 4'h1;
    end
  end

  // Transmitter: holding register, shift register and frame sequencer.
  always_ff @(posedge clk_sys) begin
    if (eng_rst) begin
      tx_st_r    <= scu_pkg::TX_IDLE;
      thr_full_r <= 1'b0;
      thr_r      <= 9'h000;
      tsr_r      <= 9'h000;
      tx_idx_r   <= 3'h0;
      stop2nd_r  <= 1'b0;
      brk_cnt_r  <= 4'h0;
    end else begin
      if (thr_load) begin
        thr_full_r <= 1'b1;
        thr_r      <= {b9ctl_r[`SCU_BC_SADDR] & ninth, thr_byte};
      end
      if (ev_take) begin
        tsr_r      <= thr_r;
        thr_full_r <= 1'b0;
      end
      if (tx_bit) begin
        case (tx_st_r)
          scu_pkg::TX_IDLE, scu_pkg::TX_STOP: begin
            if (tx_st_r == scu_pkg::TX_STOP && !stop_last) begin
              stop2nd_r <= 1'b1;
            end else if (thr_full_r) begin
              tx_st_r <= scu_pkg::TX_START;
            end else if (brk_req) begin
              // Break waits until both buffers have drained.
              tx_st_r   <= scu_pkg::TX_BREAK;
              brk_cnt_r <= 4'h0;
            end else begin
              tx_st_r <= scu_pkg::TX_IDLE;
            end
          end
          scu_pkg::TX_START: begin
            tx_st_r  <= scu_pkg::TX_DATA;
            tx_idx_r <= 3'h0;
          end
          scu_pkg::TX_DATA: begin
            tx_idx_r  <= tx_idx_r + 3'h1;
            stop2nd_r <= 1'b0;
            if (tx_idx_r == len_m1) begin
              tx_st_r <= ninth ? scu_pkg::TX_NINTH : (par_en ? scu_pkg::TX_PAR : scu_pkg::TX_STOP);
            end
          end
          scu_pkg::TX_NINTH: tx_st_r <= par_en ? scu_pkg::TX_PAR : scu_pkg::TX_STOP;
          scu_pkg::TX_PAR:   tx_st_r <= scu_pkg::TX_STOP;
          scu_pkg::TX_BREAK: begin
            if (brk_cnt_r != 4'hF) brk_cnt_r <= brk_cnt_r + 4'h1;
            if (!brk_req && brk_cnt_r >= frame_n - 4'h1) tx_st_r <= scu_pkg::TX_IDLE;
          end
          default: tx_st_r <= scu_pkg::TX_IDLE;
        endcase
      end
    end
  end

  // Receiver sequencer; the start bit is checked at its centre in async mode.
  always_ff @(posedge clk_sys) begin
    if (eng_rst) begin
      rx_st_r    <= scu_pkg::RX_IDLE;
      rx_cnt_r   <= 4'h0;
      rx_idx_r   <= 3'h0;
      rsh_r      <= 8'h00;
      r9_r       <= 1'b0;
      rpar_bad_r <= 1'b0;
      rzero_r    <= 1'b0;
    end else if (rx_src) begin
      rx_cnt_r <= rx_smp ? 4'h0 : rx_cnt_r + 4'h1;
      case (rx_st_r)
        scu_pkg::RX_IDLE: begin
          rx_cnt_r <= 4'h0;
          if (!rx_in) begin
            rsh_r      <= 8'h00;
            r9_r       <= 1'b0;
            rpar_bad_r <= 1'b0;
            rzero_r    <= 1'b1;
            rx_idx_r   <= 3'h0;
            rx_st_r    <= cd ? scu_pkg::RX_DATA : scu_pkg::RX_START;
          end
        end
        scu_pkg::RX_START: begin
          if (rx_cnt_r == `SCU_HALF_BIT) begin
            rx_cnt_r <= 4'h0;
            rx_st_r  <= rx_in ? scu_pkg::RX_IDLE : scu_pkg::RX_DATA;
          end
        end
        scu_pkg::RX_DATA: begin
          if (rx_smp) begin
            rsh_r[rx_idx_r] <= rx_in;
            rzero_r         <= rzero_r & ~rx_in;
            rx_idx_r        <= rx_idx_r + 3'h1;
            if (rx_idx_r == len_m1) begin
              rx_st_r <= ninth ? scu_pkg::RX_NINTH : (par_en ? scu_pkg::RX_PAR : scu_pkg::RX_STOP);
            end
          end
        end
        scu_pkg::RX_NINTH: begin
          if (rx_smp) begin
            r9_r    <= rx_in;
            rzero_r <= rzero_r & ~rx_in;
            rx_st_r <= par_en ? scu_pkg::RX_PAR : scu_pkg::RX_STOP;
          end
        end
        scu_pkg::RX_PAR: begin
          if (rx_smp) begin
            rpar_bad_r <= rx_in != rx_par_exp;
            rzero_r    <= rzero_r & ~rx_in;
            rx_st_r    <= scu_pkg::RX_STOP;
          end
        end
        scu_pkg::RX_STOP: if (rx_smp) rx_st_r <= rx_in ? scu_pkg::RX_IDLE : scu_pkg::RX_WAIT;
        scu_pkg::RX_WAIT: if (rx_in) rx_st_r <= scu_pkg::RX_IDLE;
        default:          rx_st_r <= scu_pkg::RX_IDLE;
      endcase
    end
  end

  // Pending flags: hardware sets, software clears by writing ones; a set wins.
  always_comb begin
    st_set = 9'h000;
    st_set[`SCU_ST_OVR] = ev_ovr;
    st_set[`SCU_ST_FRM] = ev_frm;
    st_set[`SCU_ST_PAR] = ev_par;
    st_set[`SCU_ST_RXP] = ev_word & ~dma_on_r[0];
    st_set[`SCU_ST_ADR] = ev_addr;
    st_set[`SCU_ST_BRK] = ev_brk;
    st_set[`SCU_ST_TXP] = ~dma_on_r[1] & (imask_r[`SCU_IM_TXSRC] ? ev_take : ev_tsr_mt);
    st_set[`SCU_ST_RXE] = ev_rx_eob;
    st_set[`SCU_ST_TXE] = ev_tx_eob;
  end

  wire wr_stat = do_wr & hit(aw_addr_r, `SCU_OFF_IRQ_STAT);
  wire [8:0] st_clr = wr_stat ? ({w_strb_r[1], {8{w_strb_r[0]}}} & w_data_r[8:0]) : 9'h000;
  wire lv_err = imask_r[0] & (stat_r[`SCU_ST_OVR] | stat_r[`SCU_ST_FRM] | stat_r[`SCU_ST_PAR]);
  wire lv_brk = imask_r[1] & (stat_r[`SCU_ST_ADR] | stat_r[`SCU_ST_BRK]);
  wire lv_rx  = imask_r[2] & (stat_r[`SCU_ST_RXP] | stat_r[`SCU_ST_RXE]);
  wire lv_tx  = imask_r[3] & (stat_r[`SCU_ST_TXP] | stat_r[`SCU_ST_TXE]);
  // Receive levels outrank transmit; DMA requests outrank all interrupts.
  wire [2:0] vec_lo = lv_err ? `SCU_VEC_ERR : lv_brk ? `SCU_VEC_BRK :
                      lv_rx  ? `SCU_VEC_RX  : `SCU_VEC_TX;

  always_ff @(posedge clk_sys) begin
    if (eng_rst) begin
      stat_r      <= 9'h000;
      rx_data_r   <= 9'h000;
      rx_full_r   <= 1'b0;
      after_brk_r <= 1'b0;
      irq_vec_r   <= 8'h00;
      irq_req_r   <= 1'b0;
    end else begin
      stat_r <= (stat_r & ~st_clr) | st_set;
      if (rd_rxd || dma_rx_ack) rx_full_r <= 1'b0;
      if (ev_word) begin
        rx_data_r <= {r9_r, rsh_r};
        rx_full_r <= 1'b1;
      end
      if (ev_word) after_brk_r <= 1'b0;
      if (ev_brk) after_brk_r <= 1'b1;
      irq_vec_r <= {vecbase_r[7:3], vec_lo};
      irq_req_r <= (lv_err | lv_brk | lv_rx | lv_tx) & ~rx_dma_req_r & ~dma_tx_req;
    end
  end

  // DMA channels; software writes to the enables win over end-of-block clears.
  always_ff @(posedge clk_sys) begin
    if (eng_rst) begin
      dma_on_r     <= 2'h0;
      rx_dcnt_r    <= '0;
      tx_dcnt_r    <= '0;
      rx_dma_req_r <= 1'b0;
      tx_go_r      <= 1'b0;
    end else begin
      if (dma_rx_ack) begin
        rx_dma_req_r <= 1'b0;
        rx_dcnt_r    <= rx_dcnt_r - DMA_W'(1);
        if (ev_rx_eob) dma_on_r[0] <= 1'b0;
      end
      if (ev_word && dma_on_r[0]) rx_dma_req_r <= 1'b1;
      if (dma_tx_ack) begin
        tx_dcnt_r <= tx_dcnt_r - DMA_W'(1);
        if (ev_tx_eob) begin
          dma_on_r[1] <= 1'b0;
          tx_go_r     <= 1'b0;
        end
      end
      if (wr_thr && dma_on_r[1]) tx_go_r <= 1'b1;
      if (wr_dma) dma_on_r <= w_data_r[1:0];
      if (wr_b0 && hit(aw_addr_r, `SCU_OFF_TX_CNT)) tx_dcnt_r <= w_data_r[DMA_W-1:0];
      if (wr_b0 && hit(aw_addr_r, `SCU_OFF_RX_CNT)) rx_dcnt_r <= w_data_r[DMA_W-1:0];
    end
  end

  assign dma_out.rx_req  = rx_dma_req_r;
  assign dma_out.rx_data = rx_data_r;
  assign dma_out.tx_req  = dma_tx_req;
  assign irq_request     = irq_req_r;
  assign irq_vector      = irq_vec_r;
endmodule : scu_serial_unit

// ### rtl/scu_regs.svh
`ifndef SCU_REGS_SVH
`define SCU_REGS_SVH
`define SCU_OFF_DATA     8'h00
`define SCU_OFF_CHAR_FMT 8'h04
`define SCU_OFF_BIT9_CTL 8'h08
`define SCU_OFF_IRQ_MASK 8'h0C
`define SCU_OFF_IRQ_STAT 8'h10
`define SCU_OFF_MATCH    8'h14
`define SCU_OFF_CLK_CFG  8'h18
`define SCU_OFF_BAUD_LO  8'h1C
`define SCU_OFF_BAUD_HI  8'h20
`define SCU_OFF_IRQ_VEC  8'h24
`define SCU_OFF_DMA_CTL  8'h28
`define SCU_OFF_TX_CNT   8'h2C
`define SCU_OFF_RX_CNT   8'h30
`define SCU_OFF_UNIT_ST  8'h34
`define SCU_CF_PAR_EN    2
`define SCU_CF_PAR_ODD   3
`define SCU_CF_NINTH     4
`define SCU_CF_STOP2     5
`define SCU_CF_AMODE     7
`define SCU_BC_ECHO      0
`define SCU_BC_LOOP      1
`define SCU_BC_SADDR     5
`define SCU_BC_BREAK     6
`define SCU_BC_ADDR_IRQ_MODE_ON      7
`define SCU_IM_TXSRC     7
`define SCU_CC_MODE2     2
`define SCU_CC_CD        3
`define SCU_CC_XRX       5
`define SCU_CC_TX_PIN_OUTPUT_SEL      6
`define SCU_CC_TX_CLOCK_PIN     7
`define SCU_ST_OVR       0
`define SCU_ST_FRM       1
`define SCU_ST_RXP       2
`define SCU_ST_PAR       3
`define SCU_ST_ADR       4
`define SCU_ST_BRK       5
`define SCU_ST_TXP       6
`define SCU_ST_RXE       7
`define SCU_ST_TXE       8
`define SCU_VEC_TX       3'h6
`define SCU_VEC_RX       3'h4
`define SCU_VEC_BRK      3'h1
`define SCU_VEC_ERR      3'h0
`define SCU_ASYNC_LAST   4'hF
`define SCU_HALF_BIT     4'h7
`define SCU_BAUD_RST     16'h0001
`define SCU_RESP_OKAY    2'h0
`define SCU_RESP_SLVERR  2'h2
`endif

// ### rtl/scu_pkg.sv
package scu_pkg;
  typedef enum logic [6:0] {
    TX_IDLE = 7'h01, TX_START = 7'h02, TX_DATA = 7'h04, TX_NINTH = 7'h08,
    TX_PAR = 7'h10, TX_STOP = 7'h20, TX_BREAK = 7'h40
  } scu_tx_state_e;
  typedef enum logic [6:0] {
    RX_IDLE = 7'h01, RX_START = 7'h02, RX_DATA = 7'h04, RX_NINTH = 7'h08,
    RX_PAR = 7'h10, RX_STOP = 7'h20, RX_WAIT = 7'h40
  } scu_rx_state_e;
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } scu_axil_req_s;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } scu_axil_rsp_s;
  typedef struct packed {
    logic rx_line;
    logic rx_clk;
    logic tx_clk;
  } scu_pin_in_s;
  typedef struct packed {
    logic tx_line;
    logic tx_clk_out;
    logic tx_clk_oe;
  } scu_pin_out_s;
  typedef struct packed {
    logic       rx_ack;
    logic       tx_ack;
    logic [7:0] tx_data;
  } scu_dma_in_s;
  typedef struct packed {
    logic       rx_req;
    logic [8:0] rx_data;
    logic       tx_req;
  } scu_dma_out_s;
endpackage : scu_pkg

// ### testbench/scu_serial_unit_properties.sv
`timescale 1ns/100ps
module scu_serial_unit_checker (
  // Clock and reset
  input wire logic                   clk_sys,
  input wire logic                   reset_n,
  // Watched ports
  input wire scu_pkg::scu_axil_req_s axi_req,
  input wire scu_pkg::scu_axil_rsp_s axi_rsp,
  input wire scu_pkg::scu_pin_out_s  pin_out,
  input wire scu_pkg::scu_dma_out_s  dma_out,
  input wire logic                   irq_request,
  input wire logic [7:0]             irq_vector
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_aw_w; axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready; endsequence
  sequence s_ar; axi_req.arvalid && axi_rsp.arready; endsequence
  property p_idle; $rose(reset_n) |-> pin_out.tx_line && !irq_request && !pin_out.tx_clk_oe; endproperty
  property p_wr_ans; s_aw_w |-> ##2 axi_rsp.bvalid; endproperty
  property p_rd_ans; s_ar |=> axi_rsp.rvalid; endproperty
  property p_b_hold; axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready; endproperty
  property p_r_hold; axi_rsp.rvalid |-> !axi_rsp.arready; endproperty
  property p_unmap;
    s_ar ##0 {axi_req.araddr[7:2], 2'b00} > 8'h34 |=> axi_rsp.rresp == 2'h2 && axi_rsp.rdata == 32'h0;
  endproperty
  property p_prio; dma_out.rx_req |-> !dma_out.tx_req; endproperty
  property p_vec; irq_request |-> irq_vector[2:0] inside {3'h0, 3'h1, 3'h4, 3'h6}; endproperty
  a_idle: assert property (p_idle) else $error("bad idle");
  a_wr_ans: assert property (p_wr_ans) else $error("late bvalid");
  a_rd_ans: assert property (p_rd_ans) else $error("late rvalid");
  a_b_hold: assert property (p_b_hold) else $error("ready in bresp");
  a_r_hold: assert property (p_r_hold) else $error("ready in rresp");
  a_unmap: assert property (p_unmap) else $error("bad unmapped read");
  a_prio: assert property (p_prio) else $error("dma order");
  a_vec: assert property (p_vec) else $error("bad vector");
endmodule : scu_serial_unit_checker
bind scu_serial_unit scu_serial_unit_checker u_chk (.clk_sys(clk_sys), .reset_n(reset_n), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .pin_out(pin_out), .dma_out(dma_out), .irq_request(irq_request), .irq_vector(irq_vector));

// ### testbench/scu_far_end.sv
`timescale 1ns/100ps
module scu_far_end (
  // Clock
  input  wire logic       clk_sys,
  // Frame trigger and content
  input  wire logic       send,
  input  wire logic [7:0] byte_in,
  // Line into the unit, idles at mark
  output logic            rx_line
);
  logic [9:0] frame;
  int         n;
  initial rx_line = 1'b1;
  always @(posedge clk_sys) begin
    if (send) begin
      frame = {1'b1, byte_in, 1'b0};
      for (n = 0; n < 160; n++) begin
        rx_line <= frame[n/16];
        @(posedge clk_sys);
      end
      rx_line <= 1'b1;
    end
  end
endmodule : scu_far_end

// ### testbench/scu_serial_unit_test.sv
`timescale 1ns/100ps
`include "scu_regs.svh"
module scu_serial_unit_test;
  localparam int          LIM = 200;
  logic                   clk_sys = 1'b0;
  logic                   reset_n = 1'b0;
  logic                   send    = 1'b0;
  logic                   quiet   = 1'b0;
  logic                   rx_line;
  logic                   irq;
  logic [7:0]             vec;
  logic [31:0]            rd;
  logic [1:0]             rr;
  int                     fail_count  = 0;
  int                     checks_done = 0;
  scu_pkg::scu_axil_req_s req = '0;
  scu_pkg::scu_axil_rsp_s rsp;
  scu_pkg::scu_pin_out_s  pout;
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (quiet) chk(pout.tx_line, 1'b1);
  scu_far_end far (.clk_sys(clk_sys), .send(send), .byte_in(8'hC3), .rx_line(rx_line));
  scu_serial_unit uut (.clk_sys(clk_sys), .reset_n(reset_n), .axi_req(req), .axi_rsp(rsp),
    .pin_in({rx_line, 2'b00}), .pin_out(pout), .dma_in('0), .dma_out(), .irq_request(irq), .irq_vector(vec));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %0t: %h not %h", $time, g, e);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d fails %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task automatic hang(input int k);
    if (k == LIM) begin
      fail_count++;
      final_report();
    end
  endtask : hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    req.awaddr <= a;
    req.wdata <= d;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    for (k = 0; k < LIM; k++) begin
      @(posedge clk_sys);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    hang(k);
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    int k;
    req.araddr <= a;
    req.arvalid <= 1'b1;
    for (k = 0; k < LIM; k++) begin
      @(posedge clk_sys);
      if (rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    rd = rsp.rdata;
    rr = rsp.rresp;
    hang(k);
  endtask : rdr
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rdr(a);
    chk(rd, e);
  endtask : rc
  task automatic wait_rx;
    int k;
    for (k = 0; k < LIM; k++) begin
      rdr(`SCU_OFF_UNIT_ST);
      if (rd[1] === 1'b1) break;
    end
    hang(k);
  endtask : wait_rx
  initial begin
    req.bready <= 1'b1;
    req.rready <= 1'b1;
    req.wstrb <= 4'hF;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    rc(`SCU_OFF_BAUD_LO, 32'h1);
    rc(8'h38, 32'h0);
    chk(rr, 2'h2);
    wr(`SCU_OFF_CLK_CFG, 32'h40);
    chk(pout.tx_clk_oe, 1'b1);
    wr(`SCU_OFF_CHAR_FMT, 32'h3);
    wr(`SCU_OFF_BIT9_CTL, 32'h2);
    quiet <= 1'b1;
    wr(`SCU_OFF_DATA, 32'hA5);
    wait_rx();
    quiet <= 1'b0;
    rc(`SCU_OFF_DATA, 32'hA5);
    wr(`SCU_OFF_CHAR_FMT, 32'h13);
    wr(`SCU_OFF_IRQ_MASK, 32'h2);
    wr(`SCU_OFF_BIT9_CTL, 32'h22);
    wr(`SCU_OFF_DATA, 32'h5A);
    rc(`SCU_OFF_BIT9_CTL, 32'h2);
    wait_rx();
    rc(`SCU_OFF_DATA, 32'h15A);
    rdr(`SCU_OFF_IRQ_STAT);
    chk(rd[4], 1'b1);
    chk({irq, vec[2:0]}, 4'h9);
    wr(`SCU_OFF_IRQ_STAT, 32'h1FF);
    rc(`SCU_OFF_IRQ_STAT, 32'h0);
    wr(`SCU_OFF_CHAR_FMT, 32'h83);
    wr(`SCU_OFF_MATCH, 32'hC3);
    wr(`SCU_OFF_BIT9_CTL, 32'h1);
    send <= 1'b1;
    @(posedge clk_sys);
    send <= 1'b0;
    repeat (10) begin
      repeat (8) @(posedge clk_sys);
      chk(pout.tx_line, rx_line);
      repeat (8) @(posedge clk_sys);
    end
    wait_rx();
    rc(`SCU_OFF_DATA, 32'hC3);
    rc(`SCU_OFF_IRQ_STAT, 32'h14);
    wr(`SCU_OFF_IRQ_VEC, 32'hA8);
    wr(`SCU_OFF_IRQ_MASK, 32'h4);
    @(posedge clk_sys);
    chk({irq, vec}, 9'h1AC);
    quiet <= 1'b1;
    wr(`SCU_OFF_BIT9_CTL, 32'h42);
    repeat (200) @(posedge clk_sys);
    wr(`SCU_OFF_BIT9_CTL, 32'h2);
    quiet <= 1'b0;
    rc(`SCU_OFF_IRQ_STAT, 32'h34);
    wr(`SCU_OFF_BAUD_LO, 32'h1);
    rc(`SCU_OFF_IRQ_STAT, 32'h0);
    rc(`SCU_OFF_CHAR_FMT, 32'h83);
    final_report();
  end
endmodule : scu_serial_unit_test
